/* File: rtl/pwmart_pkg.sv */
package pwmart_pkg;

  // register offsets on the 8-bit port
  localparam logic [7:0] OFS_DUTY_CH3 = 8'h31;
  localparam logic [7:0] OFS_DUTY_CH2 = 8'h32;
  localparam logic [7:0] OFS_DUTY_CH1 = 8'h33;
  localparam logic [7:0] OFS_DUTY_CH0 = 8'h34;
  localparam logic [7:0] OFS_PWM_CTRL = 8'h35;
  localparam logic [7:0] OFS_TIMER_CS = 8'h36;
  localparam logic [7:0] OFS_COUNTER = 8'h37;
  localparam logic [7:0] OFS_RELOAD = 8'h38;
  localparam logic [7:0] OFS_CAPTURE_CS = 8'h39;
  localparam logic [7:0] OFS_CAPTURE_1 = 8'h3A;
  localparam logic [7:0] OFS_CAPTURE_2 = 8'h3B;

  // timer control/status field positions
  localparam int BIT_EXT_CLOCK_SELECT = 7;
  localparam int BIT_PRESCALE_HI = 6;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_COUNTER_RUN = 3;
  localparam int BIT_FORCE_RELOAD = 2;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 1;
  localparam int BIT_OVERFLOW_FLAG = 0;

  // pwm output control fields
  localparam int BIT_OUT_ENABLE_LO = 4;
  localparam int BIT_POLARITY_LO = 0;

  // capture control/status fields
  localparam int BIT_CAPTURE_EDGE_LO = 4;
  localparam int BIT_CAPTURE_IRQ_LO = 2;
  localparam int BIT_CAPTURE_FLAG_LO = 0;

  // values after reset, and the counter top
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_PRESCALER = 7'h00;
  localparam logic [7:0] COUNTER_TOP = 8'hFF;

  // input synchroniser depth (pin inputs)
  localparam int SYNC_STAGES = 3;

  // register bus request carried as one bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pwmart_bus_s;

endpackage

/* File: rtl/pwmart_timer.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module pwmart_timer #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_clock_in,
  input wire logic [CAPTURES-1:0] capture_in_pin,
  output logic [CHANNELS-1:0] pwm_out_pin,
  output logic [CHANNELS-1:0] pwm_out_pin_oe,
  output logic overflow_irq,
  output logic [CAPTURES-1:0] capture_irq
);

  // elaboration check: register map has fixed lanes
  if (CHANNELS != 4 || CAPTURES != 2)
  begin : g_bad_param
    $error("pwmart_timer supports four channels and two captures only");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus bundle and register storage
  pwmart_pkg::pwmart_bus_s bus; // incoming request
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [7:0] duty_cycle_reg_r [CHANNELS]; // software duty values
  logic [7:0] compare_shadow_r [CHANNELS]; // hidden compare copies
  logic [CHANNELS-1:0] out_enable_r; // pin enables
  logic [CHANNELS-1:0] channel_polarity_r; // per-channel polarity
  logic ext_clock_select_r; // prescaler source
  logic [2:0] prescale_select_r; // tap select
  logic counter_run_r; // count enable
  logic overflow_irq_enable_r; // overflow irq mask
  logic overflow_flag_r; // sticky overflow
  logic [7:0] counter_r; // live counter
  logic [7:0] reload_bits_r; // auto-reload value
  logic [6:0] prescaler_r; // 7-bit prescaler
  logic [CAPTURES-1:0] capture_edge_r; // 1 rising, 0 falling
  logic [CAPTURES-1:0] capture_irq_enable_r; // capture irq masks
  logic [CAPTURES-1:0] capture_flag_r; // sticky capture flags
  logic [7:0] capture_bits_r [CAPTURES]; // latched counter values
  logic [CHANNELS-1:0] pwm_level_r; // raw waveform before polarity

  // address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change seen once stages 2 and 3 agree
  logic [pwmart_pkg::SYNC_STAGES-1:0] ext_sync_r; // external clock chain
  logic ext_level_r; // filtered external clock level
  logic ext_level_d_r; // previous filtered level

  always_ff @(posedge clock)
  begin
    // reset leaves the line low so no false edge appears
    if (rst)
    begin
      ext_sync_r <= '0;
      ext_level_r <= 1'b0;
      ext_level_d_r <= 1'b0;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clock_in};
      // second and third agree: accept new level
      if (ext_sync_r[1] == ext_sync_r[2])
      begin
        ext_level_r <= ext_sync_r[2];
      end
      ext_level_d_r <= ext_level_r;
    end
  end

  logic [pwmart_pkg::SYNC_STAGES-1:0] cap_sync_r [CAPTURES]; // capture chains
  logic [CAPTURES-1:0] cap_level_r; // filtered capture levels
  logic [CAPTURES-1:0] cap_edge; // selected edge seen this cycle

  for (genvar c = 0; c < CAPTURES; c++)
  begin : g_cap_sync
    always_ff @(posedge clock)
    begin
      // filter each capture pin the same way as the external clock
      if (rst)
      begin
        cap_sync_r[c] <= '0;
        cap_level_r[c] <= 1'b0;
      end
      else
      begin
        cap_sync_r[c] <= {cap_sync_r[c][1:0], capture_in_pin[c]};
        if (cap_sync_r[c][1] == cap_sync_r[c][2])
        begin
          cap_level_r[c] <= cap_sync_r[c][2];
        end
      end
    end
    // edge polarity chosen per channel
    assign cap_edge[c] = (cap_sync_r[c][1] == cap_sync_r[c][2]) && (cap_sync_r[c][2] != cap_level_r[c]) &&
                         (cap_sync_r[c][2] == capture_edge_r[c]);
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and counter tick
  logic input_tick; // one prescaler input event
  logic [7:0] div_mask; // low bits that must be all ones
  logic count_tick; // counter advances this cycle
  logic overflow; // counter rolls over this cycle
  logic wr_timer_cs; // write to control/status
  logic wr_counter; // write to counter access
  logic force_reload; // forced reload request

  assign wr_timer_cs = bus.wr && hit(bus.addr, pwmart_pkg::OFS_TIMER_CS);
  assign wr_counter = bus.wr && hit(bus.addr, pwmart_pkg::OFS_COUNTER);
  assign force_reload = wr_timer_cs && bus.wdata[pwmart_pkg::BIT_FORCE_RELOAD];
  // rising edge of filtered external clock, or every cpu cycle
  assign input_tick = ext_clock_select_r ? (ext_level_r && !ext_level_d_r) : 1'b1;
  assign div_mask = 8'((9'h001 << prescale_select_r) - 9'h001);
  // tap n fires when the low n prescaler bits are all ones
  assign count_tick = counter_run_r && input_tick &&
                      ((({1'b0, prescaler_r} & div_mask) == div_mask));
  assign overflow = count_tick && (counter_r == pwmart_pkg::COUNTER_TOP);

  always_ff @(posedge clock)
  begin
    // prescaler frozen while stopped; cleared by forced reload or counter write
    if (rst)
    begin
      prescaler_r <= pwmart_pkg::RESET_PRESCALER;
    end
    else if (force_reload || wr_counter)
    begin
      prescaler_r <= pwmart_pkg::RESET_PRESCALER;
    end
    else if (counter_run_r && input_tick)
    begin
      prescaler_r <= 7'(prescaler_r + 7'h01);
    end
  end

  always_ff @(posedge clock)
  begin
    // software writes win over the running count
    if (rst)
    begin
      counter_r <= pwmart_pkg::RESET_BYTE;
    end
    else if (force_reload)
    begin
      counter_r <= reload_bits_r;
    end
    else if (wr_counter)
    begin
      counter_r <= bus.wdata;
    end
    else if (overflow)
    begin
      counter_r <= reload_bits_r;
    end
    else if (count_tick)
    begin
      counter_r <= 8'(counter_r + 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clock)
  begin
    // timer control fields; force reload is not stored
    if (rst)
    begin
      ext_clock_select_r <= 1'b0;
      prescale_select_r <= 3'h0;
      counter_run_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
      reload_bits_r <= pwmart_pkg::RESET_BYTE;
    end
    else
    begin
      if (wr_timer_cs)
      begin
        ext_clock_select_r <= bus.wdata[pwmart_pkg::BIT_EXT_CLOCK_SELECT];
        prescale_select_r <= bus.wdata[pwmart_pkg::BIT_PRESCALE_HI:pwmart_pkg::BIT_PRESCALE_LO];
        counter_run_r <= bus.wdata[pwmart_pkg::BIT_COUNTER_RUN];
        overflow_irq_enable_r <= bus.wdata[pwmart_pkg::BIT_OVERFLOW_IRQ_ENABLE];
      end
      if (bus.wr && hit(bus.addr, pwmart_pkg::OFS_RELOAD))
      begin
        reload_bits_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    // overflow flag: a new overflow beats a clearing read
    if (rst)
    begin
      overflow_flag_r <= 1'b0;
    end
    else if (overflow)
    begin
      overflow_flag_r <= 1'b1;
    end
    else if (bus.rd && hit(bus.addr, pwmart_pkg::OFS_TIMER_CS))
    begin
      overflow_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    // pwm control register: output enables and polarity
    if (rst)
    begin
      out_enable_r <= '0;
      channel_polarity_r <= '0;
    end
    else if (bus.wr && hit(bus.addr, pwmart_pkg::OFS_PWM_CTRL))
    begin
      out_enable_r <= bus.wdata[pwmart_pkg::BIT_OUT_ENABLE_LO +: CHANNELS];
      channel_polarity_r <= bus.wdata[pwmart_pkg::BIT_POLARITY_LO +: CHANNELS];
    end
  end

  always_ff @(posedge clock)
  begin
    // capture control fields; flags are handled per channel
    if (rst)
    begin
      capture_edge_r <= '0;
      capture_irq_enable_r <= '0;
    end
    else if (bus.wr && hit(bus.addr, pwmart_pkg::OFS_CAPTURE_CS))
    begin
      capture_edge_r <= bus.wdata[pwmart_pkg::BIT_CAPTURE_EDGE_LO +: CAPTURES];
      capture_irq_enable_r <= bus.wdata[pwmart_pkg::BIT_CAPTURE_IRQ_LO +: CAPTURES];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm channels: duty at 34h is channel 0 down to 31h for channel 3
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_channel
    localparam logic [7:0] DUTY_OFS = 8'(pwmart_pkg::OFS_DUTY_CH0 - ch);
    always_ff @(posedge clock)
    begin
      // shadow only moves on overflow so a duty change never glitches
      if (rst)
      begin
        duty_cycle_reg_r[ch] <= pwmart_pkg::RESET_BYTE;
        compare_shadow_r[ch] <= pwmart_pkg::RESET_BYTE;
        pwm_level_r[ch] <= 1'b0;
      end
      else
      begin
        if (bus.wr && hit(bus.addr, DUTY_OFS))
        begin
          duty_cycle_reg_r[ch] <= bus.wdata;
        end
        if (overflow)
        begin
          compare_shadow_r[ch] <= duty_cycle_reg_r[ch];
        end
        // same one-cycle lag on every count, reload too, so no count is shown twice
        pwm_level_r[ch] <= (counter_r <= compare_shadow_r[ch]);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    // polarity applied on the output flop so a change shows next cycle
    if (rst)
    begin
      pwm_out_pin <= '0;
      pwm_out_pin_oe <= '0;
    end
    else
    begin
      pwm_out_pin <= (pwm_level_r ^ channel_polarity_r) & out_enable_r;
      pwm_out_pin_oe <= out_enable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input capture
  for (genvar c = 0; c < CAPTURES; c++)
  begin : g_capture
    localparam logic [7:0] CAP_OFS = 8'(pwmart_pkg::OFS_CAPTURE_1 + c);
    always_ff @(posedge clock)
    begin
      // value is locked while the flag is up; an edge in the cycle of the clearing read is lost
      if (rst)
      begin
        capture_flag_r[c] <= 1'b0;
        capture_bits_r[c] <= pwmart_pkg::RESET_BYTE;
      end
      else if (cap_edge[c] && !capture_flag_r[c])
      begin
        capture_flag_r[c] <= 1'b1;
        capture_bits_r[c] <= counter_r;
      end
      else if (bus.rd && hit(bus.addr, CAP_OFS))
      begin
        capture_flag_r[c] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    // interrupt lines are registered masked flags
    if (rst)
    begin
      overflow_irq <= 1'b0;
      capture_irq <= '0;
    end
    else
    begin
      overflow_irq <= overflow_flag_r && overflow_irq_enable_r;
      capture_irq <= capture_flag_r & capture_irq_enable_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  logic [7:0] rd_mux; // selected read value
  always_comb
  begin
    // unmapped addresses read zero
    rd_mux = 8'h00;
    case (1'b1)
      hit(bus.addr, pwmart_pkg::OFS_DUTY_CH3): rd_mux = duty_cycle_reg_r[3];
      hit(bus.addr, pwmart_pkg::OFS_DUTY_CH2): rd_mux = duty_cycle_reg_r[2];
      hit(bus.addr, pwmart_pkg::OFS_DUTY_CH1): rd_mux = duty_cycle_reg_r[1];
      hit(bus.addr, pwmart_pkg::OFS_DUTY_CH0): rd_mux = duty_cycle_reg_r[0];
      hit(bus.addr, pwmart_pkg::OFS_PWM_CTRL): rd_mux = {out_enable_r, channel_polarity_r};
      // force reload position always returns zero
      hit(bus.addr, pwmart_pkg::OFS_TIMER_CS):
        rd_mux = {ext_clock_select_r, prescale_select_r, counter_run_r, 1'b0,
                  overflow_irq_enable_r, overflow_flag_r};
      hit(bus.addr, pwmart_pkg::OFS_COUNTER): rd_mux = counter_r;
      hit(bus.addr, pwmart_pkg::OFS_RELOAD): rd_mux = reload_bits_r;
      hit(bus.addr, pwmart_pkg::OFS_CAPTURE_CS):
        rd_mux = {2'b00, capture_edge_r, capture_irq_enable_r, capture_flag_r};
      hit(bus.addr, pwmart_pkg::OFS_CAPTURE_1): rd_mux = capture_bits_r[0];
      hit(bus.addr, pwmart_pkg::OFS_CAPTURE_2): rd_mux = capture_bits_r[1];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    // data stands only in the cycle after the read strobe
    if (rst)
    begin
      reg_rdata <= pwmart_pkg::RESET_BYTE;
    end
    else
    begin
      reg_rdata <= bus.rd ? rd_mux : 8'h00;
    end
  end

endmodule

/* File: verif/pwmart_props.sv */
`timescale 1ns/100ps
// port-level checks for the timer block
module pwmart_props #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_clock_in,
  input wire logic [CAPTURES-1:0] capture_in_pin,
  input wire logic [CHANNELS-1:0] pwm_out_pin,
  input wire logic [CHANNELS-1:0] pwm_out_pin_oe,
  input wire logic overflow_irq,
  input wire logic [CAPTURES-1:0] capture_irq
);
  logic rd36_q; // status read one cycle ago
  logic wr36_q;
  logic wr39_q;
  logic [1:0] rdcap_q; // capture value reads one cycle ago
  logic ovf_en_r; // copy of the overflow irq enable
  logic [1:0] cap_en_r;
  logic [3:0] oe_r; // last enable bits written
  wire [1:0] cap_hold = capture_irq & ~rdcap_q & {2{~wr39_q}};
  // strobe delays need no reset: they only gate hold checks
  always_ff @(posedge clock)
  begin
    rd36_q <= reg_rd && reg_addr == 8'h36;
    wr36_q <= reg_wr && reg_addr == 8'h36;
    wr39_q <= reg_wr && reg_addr == 8'h39;
    rdcap_q <= {reg_rd && reg_addr == 8'h3B, reg_rd && reg_addr == 8'h3A};
  end
  // enable copies track software writes, cleared like the block
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ovf_en_r <= 1'b0;
      cap_en_r <= 2'h0;
      oe_r <= 4'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h36)
        ovf_en_r <= reg_wdata[1];
      if (reg_wr && reg_addr == 8'h39)
        cap_en_r <= reg_wdata[3:2];
      if (reg_wr && reg_addr == 8'h35)
        oe_r <= reg_wdata[7:4];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_read_zero: assert property (reg_rd && (reg_addr < 8'h31 || reg_addr > 8'h3B) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_force_reads_zero: assert property (reg_rd && reg_addr == 8'h36 |=> !reg_rdata[2])
    else $error("force reload bit read as one");
  a_capcs_top_zero: assert property (reg_rd && reg_addr == 8'h39 |=> reg_rdata[7:6] == 2'b00)
    else $error("capture status top bits set");
  a_oe_follows_write: assert property (reg_wr && reg_addr == 8'h35 |=> ##[0:1] pwm_out_pin_oe == oe_r)
    else $error("output enables not updated");
  a_pin_off_disabled: assert property ((pwm_out_pin & ~pwm_out_pin_oe) == '0)
    else $error("disabled channel drives high");
  a_ovf_irq_enabled: assert property (overflow_irq |-> $past(ovf_en_r))
    else $error("overflow irq while disabled");
  a_cap_irq_enabled: assert property ((capture_irq & ~$past(cap_en_r)) == 2'b00)
    else $error("capture irq while disabled");
  a_ovf_irq_holds: assert property (overflow_irq && !rd36_q && !wr36_q |=> overflow_irq)
    else $error("overflow irq dropped without read");
  a_cap_irq_holds: assert property (cap_hold != 2'b00 |=> (capture_irq & $past(cap_hold)) == $past(cap_hold))
    else $error("capture irq dropped without read");
  c_ovf_irq: cover property ($rose(overflow_irq));
  c_cap1_irq: cover property ($rose(capture_irq[0]));
  c_cap2_irq: cover property ($rose(capture_irq[1]));
  c_pwm_high: cover property ($rose(pwm_out_pin[0]));
endmodule
bind pwmart_timer pwmart_props #(.CHANNELS(CHANNELS), .CAPTURES(CAPTURES)) u_props (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_in(ext_clock_in),
  .capture_in_pin(capture_in_pin), .pwm_out_pin(pwm_out_pin), .pwm_out_pin_oe(pwm_out_pin_oe),
  .overflow_irq(overflow_irq), .capture_irq(capture_irq));

/* File: verif/pwmart_pin_model.sv */
`timescale 1ns/100ps
// far side pins: event clock source and capture sources
module pwmart_pin_model (
  input wire logic clock,
  output logic ext_clock_in,
  output logic [1:0] capture_in_pin
);
  // event clock stands low outside bursts; capture 2 idles high
  initial
  begin
    ext_clock_in = 1'b0;
    capture_in_pin = 2'b10;
  end
  // levels held 4 cycles so the 3-flop filter keeps them
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clock);
      ext_clock_in <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clock_in <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic set_cap(input int ch, input logic v);
    @(posedge clock);
    capture_in_pin[ch] <= v;
  endtask
endmodule

/* File: verif/tb_pwm_autoreload_timer_regs.sv */
`timescale 1ns/100ps
// self-checking bench for the auto-reload pwm timer
module tb_pwm_autoreload_timer_regs;
  logic clock;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic ext_clock_in;
  logic [1:0] capture_in_pin;
  logic [3:0] pwm_out_pin;
  logic [3:0] pwm_out_pin_oe;
  logic overflow_irq;
  logic [1:0] capture_irq;
  int fail_count;
  int n_checks;
  logic [7:0] rv; // last read data
  pwmart_timer u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_in(ext_clock_in),
    .capture_in_pin(capture_in_pin), .pwm_out_pin(pwm_out_pin), .pwm_out_pin_oe(pwm_out_pin_oe),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq));
  pwmart_pin_model u_pins (.clock(clock), .ext_clock_in(ext_clock_in), .capture_in_pin(capture_in_pin));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    n_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
      fail_count++;
    end
  endtask
  // bus master: one strobe cycle, signals moved just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    rd(a);
    chk(rv, e, w);
  endtask
  // wait, then step off the edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    for (int a = 8'h30; a <= 8'h3C; a++)
      rdc(8'(a), 8'h00, "rst val");
    for (int a = 8'h31; a <= 8'h35; a++)
    begin
      wr(8'(a), 8'(a * 3));
      rdc(8'(a), 8'(a * 3), "rw");
    end
    wr(8'h38, 8'h7E);
    rdc(8'h38, 8'h7E, "reload rw");
    wr(8'h36, 8'hF6);
    rdc(8'h36, 8'hF2, "status rw");
    rdc(8'h37, 8'h7E, "forced");
    wr(8'h39, 8'hFF);
    rdc(8'h39, 8'h3C, "cap cs");
    wr(8'h3A, 8'h55);
    rdc(8'h3A, 8'h00, "cap ro");
    wr(8'h3C, 8'h55);
    rdc(8'h3C, 8'h00, "unmapped");
    wr(8'h35, 8'h00);
    wr(8'h36, 8'h00);
    wr(8'h39, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_count();
    logic [7:0] d;
    wr(8'h37, 8'h20);
    cyc(50);
    rdc(8'h37, 8'h20, "frozen");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h36, 8'((c << 4) | 8));
      wr(8'h37, 8'h00);
      rd(8'h37);
      d = rv;
      // the next read samples the counter 128 cpu edges after d was taken
      cyc(126);
      rdc(8'h37, d + 8'(128 >> c), "prescale");
    end
    wr(8'h36, 8'h88);
    wr(8'h37, 8'h00);
    u_pins.ext_pulses(5);
    cyc(10);
    rdc(8'h37, 8'h05, "ext count");
    cyc(50);
    rdc(8'h37, 8'h05, "ext idle");
    wr(8'h36, 8'h00);
    $display("t_count done");
  endtask
  task automatic t_ovf();
    int k;
    wr(8'h38, 8'hF0);
    wr(8'h37, 8'hFE);
    wr(8'h36, 8'h08);
    cyc(40);
    wr(8'h36, 8'h00);
    cyc(2);
    chk({7'h00, overflow_irq}, 8'h00, "irq masked");
    rdc(8'h36, 8'h01, "flag set");
    rd(8'h37);
    chk({7'h00, rv >= 8'hF0}, 8'h01, "reloaded");
    rdc(8'h36, 8'h00, "flag clr");
    wr(8'h37, 8'hFE);
    wr(8'h36, 8'h0A);
    k = 0;
    while (overflow_irq !== 1'b1 && k < 50)
    begin
      cyc(1);
      k++;
    end
    wr(8'h36, 8'h02);
    cyc(3);
    chk({7'h00, overflow_irq}, 8'h01, "irq up");
    rdc(8'h36, 8'h03, "flag irq");
    cyc(3);
    chk({7'h00, overflow_irq}, 8'h00, "irq clr");
    wr(8'h38, 8'h00);
    $display("t_ovf done");
  endtask
  task automatic t_pwm();
    int hi[4];
    hi = '{0, 0, 0, 0};
    // every duty above the zero reload so channels 0 to 2 pulse; channel 3 stays disabled
    wr(8'h34, 8'h40);
    wr(8'h33, 8'hC0);
    wr(8'h32, 8'h40);
    wr(8'h31, 8'h80);
    wr(8'h35, 8'h74);
    wr(8'h36, 8'h0C);
    cyc(600);
    for (int i = 0; i < 256; i++)
    begin
      for (int c = 0; c < 4; c++)
        hi[c] += (pwm_out_pin[c] === 1'b1);
      cyc(1);
    end
    chk(8'(hi[0]), 8'h41, "ch0 high");
    chk(8'(hi[1]), 8'hC1, "ch1 high");
    chk(8'(hi[2]), 8'hBF, "ch2 inv");
    chk(8'(hi[3]), 8'h00, "ch3 off");
    chk({4'h0, pwm_out_pin_oe}, 8'h07, "oe");
    wr(8'h36, 8'h00);
    wr(8'h37, 8'h60);
    wr(8'h34, 8'h80);
    cyc(4);
    chk({4'h0, pwm_out_pin}, 8'h06, "old shadow");
    wr(8'h36, 8'h08);
    cyc(300);
    wr(8'h36, 8'h00);
    wr(8'h37, 8'h60);
    cyc(4);
    chk({4'h0, pwm_out_pin}, 8'h07, "new shadow");
    wr(8'h35, 8'h75);
    cyc(3);
    chk({4'h0, pwm_out_pin}, 8'h06, "polarity");
    wr(8'h35, 8'h05);
    cyc(3);
    chk({pwm_out_pin_oe, pwm_out_pin}, 8'h00, "all off");
    $display("t_pwm done");
  endtask
  task automatic t_cap();
    wr(8'h37, 8'h5A);
    wr(8'h39, 8'h1C);
    u_pins.set_cap(0, 1'b1);
    cyc(10);
    chk({6'h00, capture_irq}, 8'h01, "c1 irq");
    wr(8'h37, 8'h33);
    u_pins.set_cap(0, 1'b0);
    cyc(8);
    u_pins.set_cap(0, 1'b1);
    cyc(10);
    rdc(8'h3A, 8'h5A, "c1 locked");
    cyc(3);
    chk({6'h00, capture_irq}, 8'h00, "c1 clr");
    rdc(8'h39, 8'h1C, "flags clr");
    u_pins.set_cap(1, 1'b0);
    cyc(10);
    chk({6'h00, capture_irq}, 8'h02, "c2 irq");
    rdc(8'h39, 8'h1E, "c2 flag");
    rdc(8'h3B, 8'h33, "c2 value");
    u_pins.set_cap(1, 1'b1);
    cyc(10);
    rdc(8'h39, 8'h1C, "c2 edge");
    wr(8'h39, 8'h10);
    u_pins.set_cap(0, 1'b0);
    cyc(8);
    u_pins.set_cap(0, 1'b1);
    cyc(10);
    chk({6'h00, capture_irq}, 8'h00, "irq off");
    rdc(8'h39, 8'h11, "c1 flag");
    rdc(8'h3A, 8'h33, "c1 value");
    $display("t_cap done");
  endtask
  ////////////////////////////////////////
  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_count();
    t_ovf();
    t_pwm();
    t_cap();
    end_sim();
  end
  // watchdog, about nine times the expected run
  initial
  begin
    repeat (25000) @(posedge clock);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
